// ===== core/cis_defines.svh
// Constants for the instruction execution core
`ifndef CIS_DEFINES_SVH
`define CIS_DEFINES_SVH
// Flag bit positions in the flag word
`define CIS_FLAG_C 0
`define CIS_FLAG_Z 1
`define CIS_FLAG_V 2
`define CIS_FLAG_N 3
// Reset values
`define CIS_FLAGS_RST 4'h0
`define CIS_PC_RST 16'h0000
// Instruction lengths in bytes
`define CIS_LEN_SHORT 16'h0002
`define CIS_LEN_LONG 16'h0004
// Divider step counts
`define CIS_DIV_SHORT 6'h10
`define CIS_DIV_LONG 6'h20
// Vector spacing of the software vector call
`define CIS_VEC_SHIFT 2
`endif

// ===== core/cis_exec.sv
// Execution core for the 16-bit controller instruction subset
// Behaviour
// [RULE1] Add with incoming carry, word or byte
// [RULE2] Subtract with incoming borrow, word or byte
// [RULE3] Signed or unsigned 16x16 register multiply
// [RULE4] Short divide: low product word by register
// [RULE5] Long divide: 32-bit pair by register
// [RULE6] Compare, then decrease register by 1/2
// [RULE7] Compare, then increase register by 1/2
// [RULE8] Count shifts to normalize, store count
// [RULE9] Right shift copying the sign bit
// [RULE10] Byte to word, sign or zero fill
// [RULE11] Branch if bit one, optionally clear it
// [RULE12] Branch if bit zero, optionally set it
// [RULE13] Masked modify of high or low byte
// [RULE14] Copy bit or its inverse to bit
// [RULE15] Push register, then call absolute target
// [RULE16] Push register, then load it with operand
// [RULE17] Return; pop variant also restores register
// [RULE18] Vector call by immediate trap number
// [RULE19] Power-down opcode decodes, does nothing
// [RULE20] Two's complement of word or byte
// [RULE21] Own operation selector replaces opcode bits
// [RULE22] Arithmetic updates carry, zero, negative, overflow
`timescale 1ns/1ps
`include "cis_defines.svh"
module cis_exec import cis_pkg::*; #(
    parameter int STACK_DEPTH = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Instruction request
    input wire logic instr_valid,
    output logic instr_ready,
    input wire cis_op_e instr_op,
    input wire logic instr_len4,
    input wire logic instr_byte,
    input wire logic instr_signed,
    input wire logic instr_variant,
    input wire logic [3:0] instr_dst,
    input wire logic [3:0] instr_src,
    input wire logic [3:0] instr_dbit,
    input wire logic [3:0] instr_sbit,
    input wire logic [7:0] instr_rel,
    input wire logic [15:0] instr_imm,
    // Completion
    output logic done_r,
    output logic illegal_r,
    output logic taken_r,
    // Architectural state
    output logic [15:0] pc_r,
    output logic [3:0] flags_r,
    output logic [31:0] md_r,
    // Register peek
    input wire logic [3:0] peek_idx,
    output logic [15:0] peek_data_r
);
    localparam int SPW = $clog2(STACK_DEPTH);

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    cis_state_e state_r;
    logic [15:0] gpr_r [16];
    logic [15:0] stk_r [STACK_DEPTH];
    logic [SPW-1:0] sp_r;
    logic take, ok_len, exe;
    logic [15:0] rd, rs, opnd, pc_len;
    logic wr_en, md_en, div_go, br_nxt, bit_v;
    logic [15:0] wr_dat, pc_nxt, psh_a, step;
    logic [3:0] fl_nxt, amt;
    logic [31:0] md_nxt, prod;
    logic [1:0] push_n, pop_n;
    cis_alu_s alu;
    logic [5:0] div_cnt_r;
    logic [16:0] div_rem_r, sh, rem_s;
    logic [31:0] div_quo_r, quo_s, qmag, q_fix;
    logic [15:0] div_den_r, r_fix;
    logic div_long_r, div_sgn_r, div_qneg_r, div_rneg_r;
    logic ge, fin, dv_ovf, dsgn;
    logic [3:0] dv_fl;

    // Places four flag values at their bit positions
    function automatic logic [3:0] mk_fl(input logic n, v, z, c);
        mk_fl = 4'h0;
        mk_fl[`CIS_FLAG_N] = n;
        mk_fl[`CIS_FLAG_V] = v;
        mk_fl[`CIS_FLAG_Z] = z;
        mk_fl[`CIS_FLAG_C] = c;
    endfunction

    // Shared adder; subtract adds the inverted operand, carry is borrow
    function automatic cis_alu_s alu_as(input logic [15:0] a, b,
                                        input logic ci, sub, byt);
        logic [15:0] bb;
        logic [16:0] sw;
        logic [8:0] sb;
        logic am, bm, rm, co;
        cis_alu_s o;
        bb = sub ? ~b : b;
        sw = {1'b0, a} + {1'b0, bb} + {16'h0000, ci ^ sub};
        sb = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + {8'h00, ci ^ sub};
        o.res = byt ? {a[15:8], sb[7:0]} : sw[15:0];
        co = byt ? sb[8] : sw[16];
        am = byt ? a[7] : a[15];
        bm = byt ? bb[7] : bb[15];
        rm = byt ? sb[7] : sw[15];
        o.flags = mk_fl(rm, (am == bm) && (rm != am),
                        byt ? (sb[7:0] == 8'h00) : (sw[15:0] == 16'h0000),
                        co ^ sub); // [RULE22]
        return o;
    endfunction

    // Leading zero count; a zero word needs no shifts
    function automatic logic [15:0] norm_cnt(input logic [15:0] w);
        logic [15:0] n;
        logic hit;
        n = 16'h0000;
        hit = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            if (w[i]) hit = 1'b1;
            else if (!hit) n = 16'(n + 16'h0001);
        end
        return (w == 16'h0000) ? 16'h0000 : n;
    endfunction

    // Which instruction lengths each operation accepts
    function automatic logic len_ok(input cis_op_e op, input logic l4);
        case (op)
            OP_ADD_WC, OP_SUB_WB, OP_CMP_DEC, OP_CMP_INC,
            OP_EXTEND: len_ok = 1'b1;
            OP_BR_ONE, OP_BR_ZERO, OP_MASK_MOD, OP_BIT_COPY, OP_PUSH_CALL,
            OP_CTX_SW, OP_PDOWN: len_ok = l4;
            default: len_ok = !l4;
        endcase
    endfunction

    // Request handshake and operand fetch
    assign instr_ready = (state_r == ST_IDLE);
    assign take = instr_valid && instr_ready;
    assign ok_len = len_ok(instr_op, instr_len4); // [RULE21]
    assign exe = take && ok_len;
    assign rd = gpr_r[instr_dst];
    assign rs = gpr_r[instr_src];
    assign opnd = instr_len4 ? instr_imm : rs; // [RULE1] [RULE2]
    assign pc_len = 16'(pc_r + (instr_len4 ? `CIS_LEN_LONG : `CIS_LEN_SHORT));
    assign step = instr_variant ? 16'h0002 : 16'h0001;
    assign amt = rs[3:0];
    assign prod = instr_signed ?
        32'($signed({{16{rd[15]}}, rd}) * $signed({{16{rs[15]}}, rs})) :
        32'({16'h0000, rd} * {16'h0000, rs});

    // Single-cycle execution of every operation except the two divides, which only start here
    always_comb begin
        wr_en = 1'b0;
        wr_dat = rd;
        fl_nxt = flags_r;
        pc_nxt = pc_len;
        md_en = 1'b0;
        md_nxt = prod;
        push_n = 2'h0;
        pop_n = 2'h0;
        psh_a = rd;
        div_go = 1'b0;
        br_nxt = 1'b0;
        bit_v = rd[instr_dbit];
        alu = alu_as(rd, opnd, flags_r[`CIS_FLAG_C],
                     instr_op == OP_SUB_WB, instr_byte);
        case (instr_op)
            OP_ADD_WC, OP_SUB_WB: begin
                wr_en = 1'b1; // [RULE1] [RULE2]
                wr_dat = alu.res;
                fl_nxt = alu.flags;
            end
            OP_INVERT: begin
                alu = alu_as({instr_byte ? rd[15:8] : 8'h00, 8'h00}, rd,
                             1'b0, 1'b1, instr_byte); // [RULE20]
                wr_en = 1'b1;
                wr_dat = alu.res;
                fl_nxt = alu.flags;
            end
            OP_CMP_DEC, OP_CMP_INC: begin
                alu = alu_as(rd, opnd, 1'b0, 1'b1, 1'b0);
                fl_nxt = alu.flags;
                wr_en = 1'b1;
                wr_dat = (instr_op == OP_CMP_DEC) ? 16'(rd - step) :
                         16'(rd + step); // [RULE6] [RULE7]
            end
            OP_PROD: begin
                md_en = 1'b1; // [RULE3]
                fl_nxt = mk_fl(prod[31], instr_signed ?
                    (prod[31:15] != {17{prod[31]}}) :
                    (prod[31:16] != 16'h0000), prod == 32'h0, 1'b0);
            end
            OP_QUO_S, OP_QUO_L: begin
                // Division by zero sets overflow and clears N, Z and C, with no divide started
                if (rs == 16'h0000) fl_nxt = mk_fl(1'b0, 1'b1, 1'b0, 1'b0);
                else div_go = 1'b1; // [RULE4] [RULE5]
            end
            OP_NORM_CNT: begin
                wr_en = 1'b1;
                wr_dat = norm_cnt(rs); // [RULE8]
                fl_nxt = mk_fl(1'b0, 1'b0, rs == 16'h0000, 1'b0);
            end
            OP_SFILL_SHR: begin
                wr_en = 1'b1;
                wr_dat = 16'($signed(rd) >>> amt); // [RULE9]
                fl_nxt = mk_fl(wr_dat[15], 1'b0, wr_dat == 16'h0000,
                    (amt != 4'h0) && rd[amt - 4'h1]);
            end
            OP_EXTEND: begin
                wr_en = 1'b1;
                wr_dat = {{8{instr_signed & opnd[7]}}, opnd[7:0]}; // [RULE10]
                fl_nxt = mk_fl(wr_dat[15], 1'b0, wr_dat == 16'h0000, 1'b0);
            end
            OP_BR_ONE, OP_BR_ZERO: begin
                br_nxt = (instr_op == OP_BR_ONE) ? bit_v : !bit_v;
                if (br_nxt) begin
                    pc_nxt = 16'(pc_len + {{7{instr_rel[7]}}, instr_rel, 1'b0});
                    wr_en = instr_variant; // [RULE11] [RULE12]
                    wr_dat[instr_dbit] = !bit_v;
                end
            end
            OP_MASK_MOD: begin
                wr_en = 1'b1; // [RULE13]
                if (instr_variant)
                    wr_dat[15:8] = (rd[15:8] & ~instr_imm[7:0]) |
                                   (instr_imm[15:8] & instr_imm[7:0]);
                else
                    wr_dat[7:0] = (rd[7:0] & ~instr_imm[7:0]) |
                                  (instr_imm[15:8] & instr_imm[7:0]);
            end
            OP_BIT_COPY: begin
                wr_en = 1'b1; // [RULE14]
                wr_dat[instr_dbit] = rs[instr_sbit] ^ instr_variant;
            end
            OP_PUSH_CALL: begin
                push_n = 2'h2; // [RULE15]
                pc_nxt = instr_imm;
            end
            OP_CTX_SW: begin
                push_n = 2'h1; // [RULE16]
                wr_en = 1'b1;
                wr_dat = instr_imm;
            end
            OP_NEAR_RET: begin
                pop_n = instr_variant ? 2'h2 : 2'h1; // [RULE17]
                pc_nxt = stk_r[SPW'(sp_r - SPW'(1))];
                wr_en = instr_variant;
                wr_dat = stk_r[SPW'(sp_r - SPW'(2))];
            end
            OP_VEC_CALL: begin
                push_n = 2'h2; // [RULE18]
                psh_a = {12'h000, flags_r};
                pc_nxt = 16'({9'h000, instr_imm[6:0]} << `CIS_VEC_SHIFT);
            end
            OP_PDOWN: ; // [RULE19]
            default: ;
        endcase
    end

    // Register file; the divider writes only the product pair and the flags
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 16; i++) gpr_r[i] <= 16'h0000;
        end else if (exe && wr_en) begin
            gpr_r[instr_dst] <= wr_dat;
        end
    end

    // Flags, program counter and product pair
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flags_r <= `CIS_FLAGS_RST;
            pc_r <= `CIS_PC_RST;
            md_r <= 32'h00000000;
        end else begin
            if (exe) flags_r <= fl_nxt;
            else if (fin) flags_r <= dv_fl; // [RULE22]
            if (exe) pc_r <= pc_nxt;
            if (exe && md_en) md_r <= md_nxt;
            else if (fin && !dv_ovf) md_r <= {r_fix, q_fix[15:0]};
        end
    end

    // Stack pointer; overflow wraps silently, software must bound depth
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) sp_r <= '0;
        else if (exe) sp_r <= SPW'(sp_r + push_n - pop_n);
    end

    // Stack storage holds data only, so it carries no reset
    always_ff @(posedge clock) begin
        if (exe && push_n != 2'h0) begin
            stk_r[sp_r] <= psh_a;
            if (push_n == 2'h2) stk_r[SPW'(sp_r + SPW'(1))] <= pc_len;
        end
    end

    // One restoring divide step per clock on magnitudes
    assign sh = {div_rem_r[15:0], div_quo_r[31]};
    assign ge = sh >= {1'b0, div_den_r};
    assign rem_s = ge ? 17'(sh - {1'b0, div_den_r}) : sh;
    assign quo_s = {div_quo_r[30:0], ge};
    assign fin = (state_r == ST_DIVIDE) && (div_cnt_r == 6'h01);
    assign qmag = div_long_r ? quo_s : {16'h0000, quo_s[15:0]};
    assign q_fix = div_qneg_r ? 32'(-qmag) : qmag;
    assign r_fix = div_rneg_r ? 16'(-rem_s[15:0]) : rem_s[15:0];
    assign dv_ovf = div_sgn_r ?
        (qmag > (div_qneg_r ? 32'h00008000 : 32'h00007fff)) :
        (qmag[31:16] != 16'h0000);
    assign dv_fl = mk_fl(q_fix[15], dv_ovf, q_fix[15:0] == 16'h0000, 1'b0);
    assign dsgn = instr_signed &&
        ((instr_op == OP_QUO_L) ? md_r[31] : md_r[15]);

    // Divider sequencer; the core stalls requests until it finishes
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            div_cnt_r <= 6'h00;
            div_rem_r <= 17'h00000;
            div_quo_r <= 32'h00000000;
            div_den_r <= 16'h0000;
            div_long_r <= 1'b0;
            div_sgn_r <= 1'b0;
            div_qneg_r <= 1'b0;
            div_rneg_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (exe && div_go) begin
                        state_r <= ST_DIVIDE;
                        div_long_r <= (instr_op == OP_QUO_L); // [RULE5]
                        div_cnt_r <= (instr_op == OP_QUO_L) ?
                                     `CIS_DIV_LONG : `CIS_DIV_SHORT;
                        div_rem_r <= 17'h00000;
                        div_quo_r <= (instr_op == OP_QUO_L) ?
                            (dsgn ? 32'(-md_r) : md_r) :
                            {dsgn ? 16'(-md_r[15:0]) : md_r[15:0],
                             16'h0000}; // [RULE4]
                        div_den_r <= (instr_signed && rs[15]) ?
                                     16'(-rs) : rs;
                        div_sgn_r <= instr_signed;
                        div_qneg_r <= dsgn ^ (instr_signed && rs[15]);
                        div_rneg_r <= dsgn;
                    end
                end
                ST_DIVIDE: begin
                    div_rem_r <= rem_s;
                    div_quo_r <= quo_s;
                    div_cnt_r <= 6'(div_cnt_r - 6'h01);
                    if (fin) state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Completion pulses and register peek
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            done_r <= 1'b0;
            illegal_r <= 1'b0;
            taken_r <= 1'b0;
            peek_data_r <= 16'h0000;
        end else begin
            done_r <= (take && !(ok_len && div_go)) || fin;
            illegal_r <= take && !ok_len; // [RULE21]
            taken_r <= exe && br_nxt;
            peek_data_r <= gpr_r[peek_idx];
        end
    end

    // Snapshot of the last executed request, read only by checks
    logic chk_v_r, chk_c_r, chk_byte_r, chk_var_r;
    cis_op_e chk_op_r;
    logic [15:0] chk_a_r, chk_b_r;
    logic [3:0] chk_dst_r;
    always_ff @(posedge clock) begin
        chk_v_r <= exe && reset_n;
        chk_op_r <= instr_op;
        chk_a_r <= rd;
        chk_b_r <= opnd;
        chk_c_r <= flags_r[`CIS_FLAG_C];
        chk_byte_r <= instr_byte;
        chk_var_r <= instr_variant;
        chk_dst_r <= instr_dst;
    end

    AST_ADD_CARRY: assert property ( // [RULE1]
        chk_v_r && chk_op_r == OP_ADD_WC && !chk_byte_r |->
        gpr_r[chk_dst_r] == 16'(chk_a_r + chk_b_r + {15'h0, chk_c_r}))
        else $error("add with carry result wrong");
    AST_SUB_BORROW: assert property ( // [RULE2]
        chk_v_r && chk_op_r == OP_SUB_WB && !chk_byte_r |->
        gpr_r[chk_dst_r] == 16'(chk_a_r - chk_b_r - {15'h0, chk_c_r}))
        else $error("subtract with borrow result wrong");
    AST_PRODUCT: assert property ( // [RULE3]
        exe && instr_op == OP_PROD && !instr_signed |=>
        md_r == {16'h0000, chk_a_r} * {16'h0000, chk_b_r})
        else $error("unsigned product wrong");
    AST_QUO_SHORT: assert property ( // [RULE4]
        exe && instr_op == OP_QUO_S && rs != 16'h0000 |->
        ##1 !instr_ready ##16 done_r)
        else $error("short divide latency wrong");
    AST_QUO_LONG: assert property ( // [RULE5]
        exe && instr_op == OP_QUO_L && rs != 16'h0000 |->
        ##32 !done_r ##1 done_r)
        else $error("long divide latency wrong");
    AST_CMP_DEC: assert property ( // [RULE6]
        chk_v_r && chk_op_r == OP_CMP_DEC |->
        gpr_r[chk_dst_r] == 16'(chk_a_r - (chk_var_r ? 16'h2 : 16'h1)))
        else $error("compare then decrease step wrong");
    AST_CMP_INC: assert property ( // [RULE7]
        chk_v_r && chk_op_r == OP_CMP_INC |->
        gpr_r[chk_dst_r] == 16'(chk_a_r + (chk_var_r ? 16'h2 : 16'h1)))
        else $error("compare then increase step wrong");
    AST_PUSH_CALL: assert property ( // [RULE15]
        exe && instr_op == OP_PUSH_CALL |=> pc_r == $past(instr_imm) &&
        sp_r == SPW'($past(sp_r) + SPW'(2)))
        else $error("push and call target or stack wrong");
    AST_PDOWN: assert property ( // [RULE19]
        exe && instr_op == OP_PDOWN |=> done_r && $stable(flags_r) &&
        $stable(md_r) && pc_r == 16'($past(pc_r) + `CIS_LEN_LONG))
        else $error("power-down opcode had an effect");
    AST_BAD_LEN: assert property ( // [RULE21]
        take && !ok_len |=> illegal_r && done_r && $stable(pc_r))
        else $error("wrong length not refused");

    COV_LONG_DIV: cover property (exe && instr_op == OP_QUO_L ##33 done_r);
    COV_BRANCH: cover property (taken_r);
    COV_VEC_CALL: cover property (exe && instr_op == OP_VEC_CALL);
endmodule

// ===== core/cis_pkg.sv
// Types shared by the instruction execution core
package cis_pkg;
    // Operation selector supplied by the front-end decoder
    typedef enum logic [4:0] {
        OP_ADD_WC, OP_SUB_WB, OP_PROD, OP_QUO_S, OP_QUO_L,
        OP_INVERT, OP_CMP_DEC, OP_CMP_INC, OP_NORM_CNT, OP_SFILL_SHR,
        OP_EXTEND, OP_BR_ONE, OP_BR_ZERO, OP_MASK_MOD, OP_BIT_COPY,
        OP_PUSH_CALL, OP_CTX_SW, OP_NEAR_RET, OP_VEC_CALL, OP_PDOWN
    } cis_op_e;
    typedef enum logic [1:0] {ST_IDLE, ST_DIVIDE} cis_state_e;
    typedef struct packed {
        logic [3:0] flags;
        logic [15:0] res;
    } cis_alu_s;
endpackage

// ===== test/cis_exec_test.sv
// Self-checking bench for the instruction execution core
`timescale 1ns/1ps
module cis_exec_test import cis_pkg::*;;
logic clock = 1'b0;
logic reset_n = 1'b0;
logic vld = 1'b0, l4 = 1'b0, byt = 1'b0, sg = 1'b0, vr = 1'b0;
cis_op_e op = OP_PDOWN;
logic [3:0] dst = 4'h0, src = 4'h0, db = 4'h0, sb = 4'h0, pk = 4'h0;
logic [7:0] rel = 8'h00;
logic [15:0] imm = 16'h0000, epc = 16'h0000, jtg = 16'h0000;
logic rdy, done, ill, tkn, gi, gt;
logic jmp = 1'b0;
logic [15:0] pc, pkd;
logic [3:0] fl;
logic [31:0] md;
int failures = 0, checks_done = 0, seed = 68889, cyc = 0, wt = 0;

// 8 ns period
always #4 clock = ~clock;

cis_exec dut (.clock(clock), .reset_n(reset_n), .instr_valid(vld),
    .instr_ready(rdy), .instr_op(op), .instr_len4(l4), .instr_byte(byt),
    .instr_signed(sg), .instr_variant(vr), .instr_dst(dst),
    .instr_src(src), .instr_dbit(db), .instr_sbit(sb), .instr_rel(rel),
    .instr_imm(imm), .done_r(done), .illegal_r(ill), .taken_r(tkn),
    .pc_r(pc), .flags_r(fl), .md_r(md), .peek_idx(pk),
    .peek_data_r(pkd));

task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
endtask

// Hang guard, far above the few hundred cycles the run needs
always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
        failures++;
        tally_and_finish();
    end
end

task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
        failures++;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
endtask

// One request, held for one clock; pulses sampled in the done cycle
task automatic go;
    vld = 1'b1;
    @(posedge clock);
    #1 vld = 1'b0;
    wt = 0;
    while (done !== 1'b1 && wt < 40) begin
        if (wt == 8) chk("ready", 0, rdy);
        @(posedge clock);
        #1 wt++;
    end
    chk("done", 1, done);
    gi = ill;
    gt = tkn;
    epc = jmp ? jtg : epc + (l4 ? 16'h0004 : 16'h0002);
    chk("pc", epc, pc);
    jmp = 1'b0;
    @(posedge clock);
    #1;
endtask

task automatic run(cis_op_e o, logic f, logic v, logic [3:0] d,
                   logic [3:0] s);
    op = o;
    l4 = f;
    vr = v;
    dst = d;
    src = s;
    go();
endtask

// Register load through the context switch
task automatic setr(logic [3:0] i, logic [15:0] v);
    imm = v;
    run(OP_CTX_SW, 1'b1, 1'b0, i, 4'h0);
endtask

task automatic ckr(string nm, logic [3:0] i, logic [15:0] e);
    pk = i;
    @(posedge clock);
    #1 chk(nm, {16'h0, e}, {16'h0, pkd});
endtask

// Reference add/subtract; flags packed as {N, V, Z, C}
function automatic cis_alu_s arith(logic [15:0] a, logic [15:0] b,
                                   logic ci, logic s);
    logic [16:0] t;
    logic [15:0] bb;
    cis_alu_s o;
    bb = s ? ~b : b;
    t = {1'b0, a} + {1'b0, bb} + {16'h0, s ? ~ci : ci};
    o.res = t[15:0];
    o.flags = {o.res[15], a[15] == bb[15] && o.res[15] != a[15],
               o.res == 16'h0, s ? ~t[16] : t[16]};
    return o;
endfunction

// Shifts needed to bring the top one into bit 15
function automatic logic [15:0] lead(logic [15:0] v);
    int n;
    n = 0;
    if (v != 16'h0)
        while (!v[15 - n]) n++;
    return n[15:0];
endfunction

initial begin
    logic [15:0] a, b, ra, x;
    logic [31:0] p;
    logic [3:0] f0;
    cis_alu_s e;
    int i;
    repeat (10) @(posedge clock);
    #1 reset_n = 1'b1;
    chk("md", 0, md);
    chk("flags", 0, {28'h0, fl});
    // Add and subtract with carry, both lengths; 4-byte operand mirrored
    for (i = 0; i < 8; i++) begin
        a = 16'($random(seed));
        b = 16'($random(seed));
        setr(4'h1, a);
        setr(4'h2, b);
        imm = b;
        e = arith(a, b, fl[0], i[0]);
        run(i[0] ? OP_SUB_WB : OP_ADD_WC, i[1], 1'b0, 4'h1, 4'h2);
        ckr("sum", 4'h1, e.res);
        chk("flags", {28'h0, e.flags}, {28'h0, fl});
    end
    // Byte add whose carry leaves bit 7
    setr(4'h1, 16'hab80);
    setr(4'h2, 16'h0080);
    f0 = fl;
    byt = 1'b1;
    run(OP_ADD_WC, 1'b0, 1'b0, 4'h1, 4'h2);
    byt = 1'b0;
    pk = 4'h1;
    @(posedge clock);
    #1 chk("byte", {16'h0, 8'hab, 7'h0, f0[0]}, {16'h0, pkd});
    chk("carry", 1, fl[0]);
    // Products, signed and unsigned, then short divides of the low word
    for (i = 0; i < 4; i++) begin
        a = 16'($random(seed));
        b = 16'($random(seed));
        x = 16'($random(seed)) | 16'h0001;
        setr(4'h1, a);
        setr(4'h2, b);
        setr(4'h3, x);
        sg = i[0];
        // Kept apart so the signed branch is not widened as unsigned
        if (sg)
            p = $signed(a) * $signed(b);
        else
            p = a * b;
        run(OP_PROD, 1'b0, 1'b0, 4'h1, 4'h2);
        chk("prod", p, md);
        run(OP_QUO_S, 1'b0, 1'b0, 4'h3, 4'h3);
        a = p[15:0];
        if (sg)
            p = {$signed(a) % $signed(x), $signed(a) / $signed(x)};
        else
            p = {a % x, a / x};
        chk("cycles", 16, wt);
        chk("quot", p, md);
    end
    sg = 1'b0;
    // Long divide of the full pair; divisor chosen so the quotient fits
    a = 16'($random(seed));
    b = 16'($random(seed)) | 16'h8000;
    setr(4'h1, a);
    setr(4'h2, b);
    run(OP_PROD, 1'b0, 1'b0, 4'h1, 4'h2);
    run(OP_QUO_L, 1'b0, 1'b0, 4'h2, 4'h2);
    chk("cycles", 32, wt);
    chk("lquot", {16'h0, a}, md);
    // Zero divisor: quick finish, overflow set, pair untouched
    setr(4'h3, 16'h0000);
    p = md;
    run(OP_QUO_S, 1'b0, 1'b0, 4'h3, 4'h3);
    chk("vflag", 1, fl[2]);
    chk("md", p, md);
    // Length refused for the 2-byte-only multiply
    jmp = 1'b1;
    jtg = epc;
    run(OP_PROD, 1'b1, 1'b0, 4'h1, 4'h2);
    chk("illegal", 1, gi);
    chk("md", p, md);
    // Compare with step of one or two, both directions
    for (i = 0; i < 4; i++) begin
        setr(4'h4, 16'h0100);
        run(i[1] ? OP_CMP_INC : OP_CMP_DEC, 1'b0, i[0], 4'h4, 4'h5);
        a = i[0] ? 16'h0002 : 16'h0001;
        x = i[1] ? 16'h0100 + a : 16'h0100 - a;
        ckr("step", 4'h4, x);
    end
    // Normalize count over the edges of the range
    for (i = 0; i < 4; i++) begin
        a = i == 0 ? 16'h0001 : i == 1 ? 16'h8000 : i == 2 ? 16'h0 : 16'h0a00;
        setr(4'h6, a);
        run(OP_NORM_CNT, 1'b0, 1'b0, 4'h7, 4'h6);
        ckr("norm", 4'h7, lead(a));
    end
    // Sign-filling shift by three; source index equals its value
    setr(4'h8, 16'h8421);
    setr(4'h3, 16'h0003);
    run(OP_SFILL_SHR, 1'b0, 1'b0, 4'h8, 4'h3);
    ckr("shr", 4'h8, 16'hf084);
    // Byte to word with sign then zero fill
    imm = 16'h0085;
    for (i = 0; i < 2; i++) begin
        sg = ~i[0];
        run(OP_EXTEND, 1'b1, 1'b0, 4'h9, 4'h0);
        ckr("ext", 4'h9, sg ? 16'hff85 : 16'h0085);
    end
    sg = 1'b0;
    // Two's complement of a random word
    a = 16'($random(seed));
    setr(4'ha, a);
    run(OP_INVERT, 1'b0, 1'b0, 4'ha, 4'h0);
    ckr("neg", 4'ha, -a);
    // Byte form negates the low byte and leaves the high byte alone
    x = -a;
    byt = 1'b1;
    run(OP_INVERT, 1'b0, 1'b0, 4'ha, 4'h0);
    byt = 1'b0;
    ckr("negb", 4'ha, {x[15:8], a[7:0]});
    // Bit branches: taken with clear, taken with set, then not taken
    setr(4'hb, 16'h0010);
    db = 4'h4;
    rel = 8'hfe;
    jmp = 1'b1;
    jtg = epc + 16'h0004 - 16'h0004;
    run(OP_BR_ONE, 1'b1, 1'b1, 4'hb, 4'h0);
    chk("taken", 1, gt);
    ckr("clr", 4'hb, 16'h0000);
    rel = 8'h03;
    jmp = 1'b1;
    jtg = epc + 16'h000a;
    run(OP_BR_ZERO, 1'b1, 1'b1, 4'hb, 4'h0);
    chk("taken", 1, gt);
    ckr("set", 4'hb, 16'h0010);
    db = 4'h0;
    run(OP_BR_ONE, 1'b1, 1'b0, 4'hb, 4'h0);
    chk("taken", 0, gt);
    // Masked modify of high then low byte
    setr(4'hc, 16'h5a5a);
    imm = 16'hff0f;
    run(OP_MASK_MOD, 1'b1, 1'b1, 4'hc, 4'h0);
    ckr("mhi", 4'hc, 16'h5f5a);
    imm = 16'hff0f;
    run(OP_MASK_MOD, 1'b1, 1'b0, 4'hc, 4'h0);
    ckr("mlo", 4'hc, 16'h5f5f);
    // Bit copy, plain then negated
    setr(4'hd, 16'h0000);
    db = 4'hf;
    sb = 4'h0;
    run(OP_BIT_COPY, 1'b1, 1'b0, 4'hd, 4'hc);
    ckr("bcp", 4'hd, 16'h8000);
    run(OP_BIT_COPY, 1'b1, 1'b1, 4'hd, 4'hc);
    ckr("bcpn", 4'hd, 16'h0000);
    // Push and call, then return popping into another register
    setr(4'h5, 16'hbeef);
    ckr("ctx", 4'h5, 16'hbeef);
    ra = epc + 16'h0004;
    imm = 16'h0400;
    jmp = 1'b1;
    jtg = 16'h0400;
    run(OP_PUSH_CALL, 1'b1, 1'b0, 4'h5, 4'h0);
    jmp = 1'b1;
    jtg = ra;
    run(OP_NEAR_RET, 1'b0, 1'b1, 4'h6, 4'h0);
    ckr("pop", 4'h6, 16'hbeef);
    // Vector call by trap number, plain return
    ra = epc + 16'h0002;
    imm = 16'h0025;
    jmp = 1'b1;
    jtg = 16'h0094;
    run(OP_VEC_CALL, 1'b0, 1'b0, 4'h0, 4'h0);
    jmp = 1'b1;
    jtg = ra;
    run(OP_NEAR_RET, 1'b0, 1'b0, 4'h0, 4'h0);
    // Power-down opcode: legal in 4 bytes, no effect
    f0 = fl;
    p = md;
    run(OP_PDOWN, 1'b1, 1'b0, 4'h0, 4'h0);
    chk("illegal", 0, gi);
    chk("flags", {28'h0, f0}, {28'h0, fl});
    chk("md", p, md);
    tally_and_finish();
end

endmodule
